//--- logic/bram_pkg.sv
package bram_pkg;

    localparam int MEM_WORDS  = 128;
    localparam int WORD_W     = 36;
    localparam int TOTAL_BITS = 4608;
    localparam int ADDR_W     = 12;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int BYTE_W     = 8;

    // register offsets on the configuration port
    localparam logic [4:0] CTRL_OFS   = 5'h00;
    localparam logic [4:0] SHAPE_OFS  = 5'h04;
    localparam logic [4:0] SHIFT_OFS  = 5'h08;
    localparam logic [4:0] LDADDR_OFS = 5'h0C;
    localparam logic [4:0] LDHI_OFS   = 5'h10;
    localparam logic [4:0] LDLO_OFS   = 5'h14;
    localparam logic [4:0] STATUS_OFS = 5'h18;

    // field positions
    localparam int CTRL_OUTA_BIT  = 3;
    localparam int CTRL_OUTB_BIT  = 4;
    localparam int SHAPE_B_LSB    = 4;
    localparam int SHIFT_TAPS_LSB = 12;
    localparam int STATUS_PTR_LSB = 4;

    // shape codes: width is 1 << code, or 9 << (code - 3) with parity
    localparam logic [2:0] CODE_BYTE   = 3'h3;
    localparam logic [2:0] CODE_MASKED = 3'h4;
    localparam logic [2:0] CODE_WIDEST = 3'h5;

    typedef enum logic [2:0] {
        MODE_TDP, MODE_SDP, MODE_SP, MODE_FIFO, MODE_ROM, MODE_SHIFT
    } mode_t;

    typedef struct packed {
        logic       par;
        logic [2:0] code;
    } shape_t;

    typedef struct packed {
        logic        ce;
        logic        we;
        logic        clr;
        logic [11:0] addr;
        logic [35:0] data;
        logic [3:0]  mask;
    } portIn_t;

    // reset values
    localparam mode_t       MODE_RST   = MODE_TDP;
    localparam shape_t      SHAPE_RST  = 4'h0;
    localparam logic [11:0] TAPLEN_RST = 12'h001;
    localparam logic [5:0]  TAPS_RST   = 6'h01;
endpackage

//--- logic/dual_port_bram.sv
`timescale 1ns/1ps
module dual_port_bram #(
    parameter int MEM_WORDS = bram_pkg::MEM_WORDS
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [4:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [31:0]       regRdata,
    input  wire bram_pkg::portIn_t portA,
    input  wire bram_pkg::portIn_t portB,
    output logic      [35:0]       qA,
    output logic      [35:0]       qB
);

    bram_pkg::mode_t   mode, next_mode;
    bram_pkg::shape_t  shapeA, next_shapeA, shapeB, next_shapeB;
    bram_pkg::portIn_t inRegA, next_inRegA, inRegB, next_inRegB;
    logic              outRegA, next_outRegA, outRegB, next_outRegB;
    logic [11:0]       tapLen, next_tapLen, shiftPtr, next_shiftPtr;
    logic [5:0]        taps, next_taps;
    logic [6:0]        ldAddr, next_ldAddr;
    logic [3:0]        ldHi, next_ldHi;
    logic [31:0]       next_regRdata;
    logic [35:0]       q1A, next_q1A, q1B, next_q1B, next_qA, next_qB;
    logic              loadEn, cfgBad, wrEnA, wrEnB, readA, readB;
    logic [11:0]       effA;
    logic [6:0]        wIdxA, wIdxB;
    logic [35:0]       wmA, wdA, wmB, wdB, rdWordA, rdWordB, newA, baseB;
    logic [31:0]       sizeProd;

    // one array of full 36-bit words; every shape is a view of it
    logic [35:0] memory [MEM_WORDS];

    // width in bits of a shape
    function automatic logic [5:0] wbits(input bram_pkg::shape_t s);
        if (s.par)
            return 6'(9 << (s.code - bram_pkg::CODE_BYTE));
        return 6'(1 << s.code);
    endfunction

    // word index: depth times width never exceeds the array
    function automatic logic [6:0] widx(input bram_pkg::shape_t s, input logic [11:0] a);
        return 7'(a >> (3'h5 - s.code));
    endfunction

    // bit offset of the addressed slot inside its word
    function automatic logic [5:0] offs(input bram_pkg::shape_t s, input logic [11:0] a);
        logic [5:0] slot;
        if (s.par) begin
            slot = {4'h0, a[1:0] & 2'(3 >> (s.code - bram_pkg::CODE_BYTE))};
            return 6'(slot * 6'h09) << (s.code - bram_pkg::CODE_BYTE);
        end
        slot = {1'b0, a[4:0] & 5'(31 >> s.code)};
        return slot << s.code;
    endfunction

    // plain data skips the ninth bit of each lane, so mixed widths agree
    function automatic logic [35:0] spread(input logic [31:0] v);
        logic [35:0] r;
        r = '0;
        for (int j = 0; j < bram_pkg::LANES; j++) begin
            r[j*bram_pkg::LANE_W +: bram_pkg::BYTE_W] = v[j*bram_pkg::BYTE_W +: bram_pkg::BYTE_W];
        end
        return r;
    endfunction

    function automatic logic [31:0] pack(input logic [35:0] w);
        logic [31:0] r;
        r = '0;
        for (int j = 0; j < bram_pkg::LANES; j++) begin
            r[j*bram_pkg::BYTE_W +: bram_pkg::BYTE_W] = w[j*bram_pkg::LANE_W +: bram_pkg::BYTE_W];
        end
        return r;
    endfunction

    // per-bit write enable of the slice, before placement
    function automatic logic [35:0] laneEn(input bram_pkg::shape_t s, input logic [3:0] m);
        logic [35:0] e;
        int          lane;
        e = '0;
        for (int i = 0; i < bram_pkg::WORD_W; i++) begin
            lane = s.par ? i / bram_pkg::LANE_W : i / bram_pkg::BYTE_W;
            if (i < int'(wbits(s)))
                e[i] = (s.code >= bram_pkg::CODE_MASKED && lane < bram_pkg::LANES)
                     ? m[lane] : 1'b1;
        end
        return e;
    endfunction

    function automatic logic [35:0] place(input bram_pkg::shape_t s, input logic [11:0] a,
                                          input logic [35:0] v);
        if (s.par)
            return v << offs(s, a);
        return spread(v[31:0] << offs(s, a));
    endfunction

    function automatic logic [35:0] extract(input bram_pkg::shape_t s, input logic [11:0] a,
                                            input logic [35:0] w);
        logic [35:0] keep;
        keep = ~(36'hFFFFFFFFF << wbits(s));
        if (s.par)
            return (w >> offs(s, a)) & keep;
        return ({4'h0, pack(w)} >> offs(s, a)) & keep;
    endfunction

    // shape and mode legality; a bad setup blocks every port write
    always_comb begin
        sizeProd = 32'(wbits(shapeA)) * 32'(tapLen) * 32'(taps);
        cfgBad = (mode > bram_pkg::MODE_SHIFT)
              || (shapeA.code > bram_pkg::CODE_WIDEST) || (shapeB.code > bram_pkg::CODE_WIDEST)
              || (shapeA.par && shapeA.code < bram_pkg::CODE_BYTE)
              || (shapeB.par && shapeB.code < bram_pkg::CODE_BYTE);
        if (mode == bram_pkg::MODE_SDP || mode == bram_pkg::MODE_FIFO)
            cfgBad = cfgBad || (shapeA.par != shapeB.par);
        if (mode == bram_pkg::MODE_TDP)
            cfgBad = cfgBad || (shapeA.par != shapeB.par)
                  || shapeA.code == bram_pkg::CODE_WIDEST
                  || shapeB.code == bram_pkg::CODE_WIDEST;
        if (mode == bram_pkg::MODE_SHIFT)
            cfgBad = cfgBad || tapLen == 12'h000
                  || sizeProd > 32'(bram_pkg::TOTAL_BITS);
    end

    // port roles per mode; simple dual writes on A and reads on B
    always_comb begin
        effA  = (mode == bram_pkg::MODE_SHIFT) ? shiftPtr : inRegA.addr;
        wIdxA = widx(shapeA, effA);
        wIdxB = widx(shapeB, inRegB.addr);
        wrEnA = inRegA.ce && !cfgBad && mode != bram_pkg::MODE_ROM
             && (inRegA.we || mode == bram_pkg::MODE_SHIFT);
        wrEnB = inRegB.ce && inRegB.we && !cfgBad && mode == bram_pkg::MODE_TDP;
        readA = inRegA.ce && (!inRegA.we || mode == bram_pkg::MODE_SHIFT)
             && mode != bram_pkg::MODE_SDP && mode != bram_pkg::MODE_FIFO;
        readB = inRegB.ce && !inRegB.we
             && mode != bram_pkg::MODE_SP && mode != bram_pkg::MODE_SHIFT;
        wmA = place(shapeA, effA, laneEn(shapeA, inRegA.mask));
        wdA = place(shapeA, effA, inRegA.data);
        wmB = place(shapeB, inRegB.addr, laneEn(shapeB, inRegB.mask));
        wdB = place(shapeB, inRegB.addr, inRegB.data);
        // reads see the word before this edge's write: read-before-write
        rdWordA = extract(shapeA, effA, memory[wIdxA]);
        rdWordB = extract(shapeB, inRegB.addr, memory[wIdxB]);
        newA  = (memory[wIdxA] & ~wmA) | (wdA & wmA);
        // same-word writes merge so A's lanes survive; B wins overlapping bits
        baseB = (wrEnA && wIdxA == wIdxB) ? newA : memory[wIdxB];
    end

    // array update; a preload from the register port takes precedence
    always_ff @(posedge sys_clk) begin
        if (loadEn) begin
            memory[ldAddr] <= {ldHi, regWdata};
        end else begin
            if (wrEnA)
                memory[wIdxA] <= newA;
            if (wrEnB)
                memory[wIdxB] <= (baseB & ~wmB) | (wdB & wmB);
        end
    end

    // input registers: always present, cleared by the port clear
    always_comb begin
        next_inRegA    = inRegA;
        next_inRegA.ce = 1'b0;
        next_inRegB    = inRegB;
        next_inRegB.ce = 1'b0;
        if (portA.clr)
            next_inRegA = '0;
        else if (portA.ce)
            next_inRegA = portA;
        if (portB.clr)
            next_inRegB = '0;
        else if (portB.ce)
            next_inRegB = portB;
    end

    // shift pointer walks the tap length one slot per enabled cycle
    always_comb begin
        next_shiftPtr = shiftPtr;
        if (mode != bram_pkg::MODE_SHIFT)
            next_shiftPtr = 12'h000;
        else if (inRegA.ce)
            next_shiftPtr = (shiftPtr == tapLen - 12'h001) ? 12'h000 : shiftPtr + 12'h001;
    end

    // output stage: q1 holds the last read, q is bypass or registered view
    always_comb begin
        next_q1A = readA ? rdWordA : q1A;
        next_q1B = readB ? rdWordB : q1B;
        next_qA  = outRegA ? q1A : (readA ? rdWordA : qA);
        next_qB  = outRegB ? q1B : (readB ? rdWordB : qB);
        if (portA.clr) begin
            next_q1A = '0;
            next_qA  = '0;
        end
        if (portB.clr) begin
            next_q1B = '0;
            next_qB  = '0;
        end
    end

    // register port decode; read data lives for one cycle only
    always_comb begin
        next_mode     = mode;
        next_outRegA  = outRegA;
        next_outRegB  = outRegB;
        next_shapeA   = shapeA;
        next_shapeB   = shapeB;
        next_tapLen   = tapLen;
        next_taps     = taps;
        next_ldAddr   = ldAddr;
        next_ldHi     = ldHi;
        next_regRdata = '0;
        loadEn        = 1'b0;
        if (regWrite) begin
            if (regAddr == bram_pkg::CTRL_OFS) begin
                next_mode    = bram_pkg::mode_t'(regWdata[2:0]);
                next_outRegA = regWdata[bram_pkg::CTRL_OUTA_BIT];
                next_outRegB = regWdata[bram_pkg::CTRL_OUTB_BIT];
            end else if (regAddr == bram_pkg::SHAPE_OFS) begin
                next_shapeA = regWdata[3:0];
                next_shapeB = regWdata[bram_pkg::SHAPE_B_LSB +: 4];
            end else if (regAddr == bram_pkg::SHIFT_OFS) begin
                next_tapLen = regWdata[11:0];
                next_taps   = regWdata[bram_pkg::SHIFT_TAPS_LSB +: 6];
            end else if (regAddr == bram_pkg::LDADDR_OFS) begin
                next_ldAddr = regWdata[6:0];
            end else if (regAddr == bram_pkg::LDHI_OFS) begin
                next_ldHi = regWdata[3:0];
            end else if (regAddr == bram_pkg::LDLO_OFS) begin
                loadEn      = 1'b1;
                next_ldAddr = ldAddr + 7'h01;
            end
        end
        if (regRead) begin
            if (regAddr == bram_pkg::CTRL_OFS)
                next_regRdata = {27'h0, outRegB, outRegA, mode};
            else if (regAddr == bram_pkg::SHAPE_OFS)
                next_regRdata = {24'h0, shapeB, shapeA};
            else if (regAddr == bram_pkg::SHIFT_OFS)
                next_regRdata = {14'h0, taps, tapLen};
            else if (regAddr == bram_pkg::LDADDR_OFS)
                next_regRdata = {25'h0, ldAddr};
            else if (regAddr == bram_pkg::LDHI_OFS)
                next_regRdata = {28'h0, ldHi};
            else if (regAddr == bram_pkg::STATUS_OFS)
                next_regRdata = {16'h0, shiftPtr, 3'h0, cfgBad};
        end
    end

    // single clock: both ports and every stage share sys_clk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode     <= bram_pkg::MODE_RST;
            outRegA  <= 1'b0;
            outRegB  <= 1'b0;
            shapeA   <= bram_pkg::SHAPE_RST;
            shapeB   <= bram_pkg::SHAPE_RST;
            tapLen   <= bram_pkg::TAPLEN_RST;
            taps     <= bram_pkg::TAPS_RST;
            ldAddr   <= 7'h00;
            ldHi     <= 4'h0;
            regRdata <= 32'h0;
            inRegA   <= '0;
            inRegB   <= '0;
            shiftPtr <= 12'h000;
            q1A      <= 36'h0;
            q1B      <= 36'h0;
            qA       <= 36'h0;
            qB       <= 36'h0;
        end else begin
            mode     <= next_mode;
            outRegA  <= next_outRegA;
            outRegB  <= next_outRegB;
            shapeA   <= next_shapeA;
            shapeB   <= next_shapeB;
            tapLen   <= next_tapLen;
            taps     <= next_taps;
            ldAddr   <= next_ldAddr;
            ldHi     <= next_ldHi;
            regRdata <= next_regRdata;
            inRegA   <= next_inRegA;
            inRegB   <= next_inRegB;
            shiftPtr <= next_shiftPtr;
            q1A      <= next_q1A;
            q1B      <= next_q1B;
            qA       <= next_qA;
            qB       <= next_qB;
        end
    end

    // helper for the lane check: word before a port A write
    logic [6:0]  chkIdx;
    logic [35:0] chkOld;
    always_ff @(posedge sys_clk) begin
        chkIdx <= wIdxA;
        chkOld <= memory[wIdxA];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_rom_locked: assert property (mode == bram_pkg::MODE_ROM |-> !wrEnA && !wrEnB)
        else $error("write reached the array in rom mode");
    chk_tdp_wide: assert property ((mode == bram_pkg::MODE_TDP && inRegA.ce && inRegA.we
        && shapeA.code == bram_pkg::CODE_WIDEST) |-> !wrEnA)
        else $error("widest shape wrote in true dual-port mode");
    chk_parity_pair: assert property ((mode == bram_pkg::MODE_SDP
        && shapeA.par != shapeB.par) |-> !wrEnA)
        else $error("parity and plain shapes mixed");
    chk_port_b: assert property ((mode == bram_pkg::MODE_TDP && !cfgBad
        && inRegB.ce && inRegB.we) |-> wrEnB)
        else $error("port b write lost in true dual-port mode");
    chk_narrow_mask: assert property ((wrEnA && shapeA.code < bram_pkg::CODE_MASKED)
        |-> $countones(wmA) == int'(wbits(shapeA)))
        else $error("narrow write was byte masked");
    chk_lane_keep: assert property ((wrEnA && !wrEnB && !loadEn && inRegA.mask == 4'h0
        && shapeA.code >= bram_pkg::CODE_MASKED) |=> memory[chkIdx] == chkOld)
        else $error("masked-off lanes changed");
    chk_read_bypass: assert property ((readA && !outRegA && !portA.clr)
        |=> qA == $past(rdWordA))
        else $error("bypassed read data wrong");
    chk_read_piped: assert property ((readA && outRegA && !portA.clr) ##1
        (outRegA && !portA.clr) |=> qA == $past(rdWordA, 2))
        else $error("registered read data wrong");
    chk_clear_now: assert property (portA.clr |=> qA == 36'h0 && q1A == 36'h0
        && !inRegA.ce)
        else $error("port clear did not clear the registers");
    chk_shift_wrap: assert property ((mode == bram_pkg::MODE_SHIFT && inRegA.ce
        && shiftPtr == tapLen - 12'h001) |=> shiftPtr == 12'h000)
        else $error("shift pointer failed to wrap");

    cov_both_write: cover property (wrEnA && wrEnB && wIdxA == wIdxB);
    cov_masked: cover property (wrEnA && shapeA.code >= bram_pkg::CODE_MASKED
        && inRegA.mask == 4'h5);
    cov_shift_wrap: cover property (mode == bram_pkg::MODE_SHIFT && inRegA.ce
        && shiftPtr == tapLen - 12'h001);
    cov_piped_read: cover property (readA && outRegA ##2 qA != 36'h0);

endmodule // dual_port_bram

//--- verif/dual_port_bram_tb.sv
`timescale 1ns/1ps
module dual_port_bram_tb;
    localparam int                TAPLEN = 5;
    localparam bram_pkg::portIn_t NOP    = '0;
    localparam bram_pkg::portIn_t CLR    = '{ce: 1'b0, we: 1'b0, clr: 1'b1, addr: 12'h000,
                                             data: 36'h0, mask: 4'h0};
    logic              sys_clk      = 1'b0;
    logic              rst          = 1'b1;
    logic [4:0]        regAddr      = 5'h00;
    logic [31:0]       regWdata     = 32'h0;
    logic              regWrite     = 1'b0;
    logic              regRead      = 1'b0;
    logic [31:0]       regRdata;
    bram_pkg::portIn_t portA;
    bram_pkg::portIn_t portB;
    logic [35:0]       qA;
    logic [35:0]       qB;
    logic [35:0]       w [4];
    logic [3:0]        masks [4];
    logic [35:0]       e;
    int                err_total    = 0;
    int                total_checks = 0;
    int                k;

    dual_port_bram dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .portA(portA), .portB(portB), .qA(qA), .qB(qB));
    fabric_ports fab (.sys_clk(sys_clk), .portA(portA), .portB(portB));

    // 40 MHz
    always #12.5 sys_clk = ~sys_clk;

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic regWr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic regChk(input logic [4:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 check({4'h0, regRdata}, {4'h0, x});
    endtask

    task automatic cfg(input logic [31:0] c, input logic [31:0] s, input logic [31:0] t);
        regWr(bram_pkg::CTRL_OFS, c);
        regWr(bram_pkg::SHAPE_OFS, s);
        regWr(bram_pkg::SHIFT_OFS, t);
    endtask

    task automatic cfgChk(input logic [31:0] c, input logic [31:0] s, input logic [31:0] t,
                          input logic bad);
        cfg(c, s, t);
        regChk(bram_pkg::STATUS_OFS, {31'h0, bad});
    endtask

    function automatic bram_pkg::portIn_t pr(input logic we, input logic [11:0] a,
                                             input logic [35:0] d, input logic [3:0] m);
        pr = '{ce: 1'b1, we: we, clr: 1'b0, addr: a, data: d, mask: m};
    endfunction

    // request, release, then settle past the bypass read latency
    task automatic go(input bram_pkg::portIn_t a, input bram_pkg::portIn_t b);
        fab.hold(a, b);
        fab.idle();
        @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                          input logic [3:0] m);
        for (int i = 0; i < 4; i++)
            if (m[i])
                o[9*i +: 9] = n[9*i +: 9];
        return o;
    endfunction

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        err_total++;
        summarize();
    end

    initial begin
        w[0] = 36'h9_1234_5678;
        w[1] = 36'h3_0F0F_A5A5;
        w[2] = 36'hC_DEAD_0001;
        w[3] = 36'h5_8001_7FFE;
        masks[0] = 4'h0;
        masks[1] = 4'h5;
        masks[2] = 4'hA;
        masks[3] = 4'hF;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        regChk(bram_pkg::CTRL_OFS, 32'h0);
        regChk(bram_pkg::SHIFT_OFS, 32'h1001);
        regChk(5'h1C, 32'h0);
        check(qA, 36'h0);
        // preload four full words, then read them back as x36
        regWr(bram_pkg::LDADDR_OFS, 32'h0);
        for (k = 0; k < 4; k++) begin
            regWr(bram_pkg::LDHI_OFS, {28'h0, w[k][35:32]});
            regWr(bram_pkg::LDLO_OFS, w[k][31:0]);
        end
        cfg(32'h2, 32'h0D, 32'h1001);
        for (k = 0; k < 4; k++) begin
            go(pr(1'b0, 12'(k), 36'h0, 4'h0), NOP);
            check(qA, w[k]);
        end
        // masked writes keep the lanes that are off, spare bits included
        e = w[1];
        for (k = 0; k < 4; k++) begin
            go(pr(1'b1, 12'h001, {9{4'(k + 6)}}, masks[k]), NOP);
            e = merge(e, {9{4'(k + 6)}}, masks[k]);
            go(pr(1'b0, 12'h001, 36'h0, 4'h0), NOP);
            check(qA, e);
        end
        // output register adds one edge; bypass value must not show early
        regWr(bram_pkg::CTRL_OFS, 32'hA);
        go(pr(1'b0, 12'h000, 36'h0, 4'h0), NOP);
        check(qA, e);
        @(posedge sys_clk);
        #1 check(qA, w[0]);
        fab.hold(CLR, NOP);
        fab.idle();
        #1 check(qA, 36'h0);
        // refused writes: true dual with x36, then read-only mode
        cfg(32'h0, 32'h0D, 32'h1001);
        go(pr(1'b1, 12'h000, 36'h0, 4'hF), NOP);
        regWr(bram_pkg::CTRL_OFS, 32'h4);
        go(pr(1'b1, 12'h000, 36'h0, 4'hF), NOP);
        go(pr(1'b0, 12'h000, 36'h0, 4'h0), NOP);
        check(qA, w[0]);
        // legal and illegal shape pairings and shift sizes
        cfgChk(32'h0, 32'h0D, 32'h1001, 1'b1);
        cfgChk(32'h1, 32'hDD, 32'h1001, 1'b0);
        cfgChk(32'h1, 32'h5D, 32'h1001, 1'b1);
        cfgChk(32'h0, 32'hCB, 32'h1001, 1'b0);
        cfgChk(32'h0, 32'hC3, 32'h1001, 1'b1);
        cfgChk(32'h0, 32'h42, 32'h1001, 1'b0);
        cfgChk(32'h0, 32'h0A, 32'h1001, 1'b1);
        cfgChk(32'h5, 32'h0B, 32'h1200, 1'b0);
        cfgChk(32'h5, 32'h0B, 32'h1201, 1'b1);
        cfgChk(32'h6, 32'h00, 32'h1001, 1'b1);
        cfgChk(32'h3, 32'h5D, 32'h1001, 1'b1);
        // fifo storage: A only writes, B only reads; the other roles must be ignored
        cfg(32'h3, 32'hDD, 32'h1001);
        go(pr(1'b1, 12'h002, 36'h6_0C0C_3A3A, 4'hF), pr(1'b1, 12'h002, 36'h0, 4'hF));
        go(pr(1'b0, 12'h002, 36'h0, 4'h0), pr(1'b0, 12'h002, 36'h0, 4'h0));
        check(qB, 36'h6_0C0C_3A3A);
        check(qA, w[0]);
        // both ports at once in x16, then a lane-masked write
        cfg(32'h0, 32'h44, 32'h1001);
        go(pr(1'b1, 12'h010, 36'h1111, 4'hF), pr(1'b1, 12'h011, 36'h2222, 4'hF));
        go(pr(1'b1, 12'h010, 36'hAAAA, 4'h2), pr(1'b0, 12'h011, 36'h0, 4'h0));
        check(qB, 36'h2222);
        go(pr(1'b0, 12'h010, 36'h0, 4'h0), pr(1'b0, 12'h011, 36'h0, 4'h0));
        check(qA, 36'hAA11);
        check(qB, 36'h2222);
        // x8 writes ignore the mask
        cfg(32'h0, 32'h33, 32'h1001);
        go(pr(1'b1, 12'h020, 36'h5C, 4'h0), NOP);
        go(pr(1'b0, 12'h020, 36'h0, 4'h0), NOP);
        check(qA, 36'h5C);
        // shift mode: one set bit comes back after the tap length plus latency
        cfg(32'h5, 32'h00, 32'h1000 + TAPLEN);
        for (k = 0; k < 8; k++)
            fab.hold(pr(1'b0, 12'h0, 36'h0, 4'h0), NOP);
        fab.hold(pr(1'b0, 12'h0, 36'h1, 4'h0), NOP);
        #1;
        for (k = 1; k < 20 && qA[0] !== 1'b1; k++) begin
            fab.hold(pr(1'b0, 12'h0, 36'h0, 4'h0), NOP);
            #1;
        end
        fab.idle();
        check(36'(k), 36'(TAPLEN + 3));
        summarize();
    end
endmodule // dual_port_bram_tb

//--- verif/fabric_ports.sv
`timescale 1ns/1ps
// fabric side of the block: drives both memory ports on the rising edge
module fabric_ports (
    input  wire logic         sys_clk,
    output bram_pkg::portIn_t portA,
    output bram_pkg::portIn_t portB
);
    // ports start idle, with no clock enable and no clear
    initial begin
        portA = '0;
        portB = '0;
    end

    // one request per port, held until the next sampling edge
    task automatic hold(input bram_pkg::portIn_t a, input bram_pkg::portIn_t b);
        @(posedge sys_clk);
        portA <= a;
        portB <= b;
    endtask

    // released lines flip so a stale value never passes for a fresh one
    task automatic idle();
        @(posedge sys_clk);
        portA <= '{ce: 1'b0, we: ~portA.we, clr: 1'b0, addr: ~portA.addr,
                   data: ~portA.data, mask: ~portA.mask};
        portB <= '{ce: 1'b0, we: ~portB.we, clr: 1'b0, addr: ~portB.addr,
                   data: ~portB.data, mask: ~portB.mask};
    endtask
endmodule // fabric_ports
